// [logic/led_sink_pkg.sv]
package led_sink_pkg;

    // Channel count and APB address width
    localparam int CH_N     = 8;
    localparam int ADDR_W   = 12;

    // Clock rate, for reference by the bench
    localparam int PCLK_PERIOD_NS = 40;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFF     = 12'h000;
    localparam logic [11:0] STATE_OFF    = 12'h004;
    localparam logic [11:0] IRQ_STAT_OFF = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h00c;

    // Control register fields
    localparam int CTRL_VLED_BIT = 0;

    // State register fields
    localparam int STATE_MODE_BIT = 0;
    localparam int STATE_OUT_LSB  = 8;
    localparam int STATE_CFG_LSB  = 16;
    localparam int STATE_ERR_LSB  = 24;

    // Interrupt status and mask fields
    localparam int IRQ_W        = 3;
    localparam int IRQ_ERR_BIT  = 0;
    localparam int IRQ_MODE_BIT = 1;
    localparam int IRQ_CFG_BIT  = 2;

    // Reset values
    localparam logic       CTRL_VLED_RST = 1'b0;
    localparam logic [7:0] LATCH_RST     = 8'h00;
    localparam logic [2:0] IRQ_MASK_RST  = 3'h0;

    // Operating mode
    typedef enum logic {
        MODE_NORMAL  = 1'b0,
        MODE_SPECIAL = 1'b1
    } mode_t;

    // Mode switch pulse tracker, advanced on shift clock edges
    typedef enum logic [1:0] {
        SW_HIGH = 2'b00,
        SW_LOW1 = 2'b01,
        SW_LONG = 2'b10
    } sw_state_t;

    // Control pins from the controller
    typedef struct packed {
        logic shift_clk;
        logic serial_in;
        logic latch_strobe_mode_sel;
        logic output_enable_n_mode_ctl;
    } pins_t;

    // Idle pin levels: strobe pulled down, enable pulled up
    localparam logic [3:0] PINS_RST = 4'h1;

    // Per-channel fault detector flags
    typedef struct packed {
        logic [7:0] over_temp;
        logic [7:0] open_load;
        logic [7:0] short_gnd;
        logic [7:0] short_vled;
    } faults_t;

endpackage

// [logic/sync2.sv]
`timescale 1ns/1ps
module sync2 #(
    parameter int          WIDTH = 4,
    parameter logic [31:0] RST   = 32'h0
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Asynchronous input and its synchronised copy
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;

    // Two stages; the first is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= RST[WIDTH-1:0];
            dout   <= RST[WIDTH-1:0];
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

// [logic/led_sink_serial_control.sv]
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - One error bit per channel, any fault sets
// - Shift on clock edge; strobe high loads outputs
// - Special mode strobe loads configuration latch
// - Error status read out serially on request
// - Return to normal clears all error bits
// - Enable low drives outputs in every mode
// - One-clock enable low pulse; strobe picks mode
// - Error status loaded, then shifted bit per edge
// - Enable high blanks all eight outputs
// - Configuration code sets global current gain
module led_sink_serial_control (
    // APB clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Controller pins
    input  wire led_sink_pkg::pins_t pins,
    output logic                     serial_out,
    // Fault detectors and channel drive
    input  wire led_sink_pkg::faults_t faults,
    output logic      [7:0]          sink_outputs,
    output logic      [7:0]          current_gain_code,
    // Interrupt
    output logic                     irq
);

    led_sink_pkg::pins_t     pins_s;
    led_sink_pkg::faults_t   faults_s;
    logic                    clk_d_r, clk_d_nxt;
    logic                    strobe_d_r, strobe_d_nxt;
    logic [7:0]              shift_r, shift_nxt;
    logic [7:0]              out_r, out_nxt;
    logic [7:0]              cfg_nxt;
    logic [7:0]              err_r, err_nxt;
    logic [7:0]              err_set;
    logic [7:0]              sink_nxt;
    logic                    sout_nxt;
    led_sink_pkg::mode_t     mode_r, mode_nxt;
    led_sink_pkg::sw_state_t sw_r, sw_nxt;
    logic                    le_cap_r, le_cap_nxt;
    logic                    vled_en_r, vled_en_nxt;
    logic [2:0]              istat_r, istat_nxt;
    logic [2:0]              imask_r, imask_nxt;
    logic [2:0]              ev;
    logic                    irq_nxt;
    logic [31:0]             rdata_nxt;
    logic                    ready_nxt, err_resp_nxt;
    logic                    edge_c, oe_n, le, special, to_normal;
    logic                    wr_en, hit;

    // Pins and fault flags come from other domains
    sync2 #(.WIDTH(4), .RST({28'h0, led_sink_pkg::PINS_RST})) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (pins),
        .dout    (pins_s)
    );

    sync2 #(.WIDTH(32), .RST(32'h0)) u_fault_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (faults),
        .dout    (faults_s)
    );

    assign oe_n    = pins_s.output_enable_n_mode_ctl;
    assign le      = pins_s.latch_strobe_mode_sel;
    assign edge_c  = pins_s.shift_clk & ~clk_d_r;
    assign special = (mode_r == led_sink_pkg::MODE_SPECIAL);

    // Mode switch: a lone low enable sample between highs
    always_comb begin
        sw_nxt     = sw_r;
        le_cap_nxt = le_cap_r;
        mode_nxt   = mode_r;
        to_normal  = 1'b0;
        if (edge_c) begin
            case (sw_r)
                led_sink_pkg::SW_HIGH: begin
                    if (!oe_n) begin
                        sw_nxt     = led_sink_pkg::SW_LOW1;
                        le_cap_nxt = le;
                    end
                end
                led_sink_pkg::SW_LOW1: begin
                    if (oe_n) begin
                        // Relies on the controller's clean sequence
                        sw_nxt    = led_sink_pkg::SW_HIGH;
                        mode_nxt  = le_cap_r ? led_sink_pkg::MODE_SPECIAL
                                             : led_sink_pkg::MODE_NORMAL;
                        to_normal = ~le_cap_r & special;
                    end else begin
                        sw_nxt = led_sink_pkg::SW_LONG;
                    end
                end
                led_sink_pkg::SW_LONG: begin
                    if (oe_n) begin
                        sw_nxt = led_sink_pkg::SW_HIGH;
                    end
                end
                default: sw_nxt = led_sink_pkg::SW_HIGH;
            endcase
        end
    end

    // Shift path, latches and error bits
    always_comb begin
        clk_d_nxt    = pins_s.shift_clk;
        strobe_d_nxt = le;
        shift_nxt    = shift_r;
        out_nxt      = out_r;
        cfg_nxt      = current_gain_code;
        if (edge_c) begin
            if (special && !oe_n) begin
                shift_nxt = err_r;
            end else begin
                shift_nxt = {shift_r[6:0], pins_s.serial_in};
            end
        end
        if (le && !special) begin
            out_nxt = shift_r;
        end
        if (le && special) begin
            cfg_nxt = shift_r;
        end
        // Detection only while channels are driven
        err_set = (faults_s.over_temp | faults_s.open_load
                  | faults_s.short_gnd
                  | (faults_s.short_vled & {8{vled_en_r}}))
                  & {8{special & ~oe_n}};
        // Nothing lands in the clearing cycle: err_set needs enable low
        err_nxt  = (to_normal ? 8'h00 : err_r) | err_set;
        sink_nxt = oe_n ? 8'h00 : out_nxt;
        sout_nxt = shift_nxt[7];
    end

    // Pin side registers; all cleared since the pins carry no reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_d_r           <= 1'b0;
            strobe_d_r        <= 1'b0;
            shift_r           <= led_sink_pkg::LATCH_RST;
            out_r             <= led_sink_pkg::LATCH_RST;
            current_gain_code <= led_sink_pkg::LATCH_RST;
            err_r             <= led_sink_pkg::LATCH_RST;
            sink_outputs      <= led_sink_pkg::LATCH_RST;
            serial_out        <= 1'b0;
            mode_r            <= led_sink_pkg::MODE_NORMAL;
            sw_r              <= led_sink_pkg::SW_HIGH;
            le_cap_r          <= 1'b0;
        end else begin
            clk_d_r           <= clk_d_nxt;
            strobe_d_r        <= strobe_d_nxt;
            shift_r           <= shift_nxt;
            out_r             <= out_nxt;
            current_gain_code <= cfg_nxt;
            err_r             <= err_nxt;
            sink_outputs      <= sink_nxt;
            serial_out        <= sout_nxt;
            mode_r            <= mode_nxt;
            sw_r              <= sw_nxt;
            le_cap_r          <= le_cap_nxt;
        end
    end

    // Events: new error bit, mode change, configuration write
    assign ev[led_sink_pkg::IRQ_ERR_BIT]  = |(err_set & ~err_r);
    assign ev[led_sink_pkg::IRQ_MODE_BIT] = (mode_nxt != mode_r);
    assign ev[led_sink_pkg::IRQ_CFG_BIT]  = special & le & ~strobe_d_r;

    assign wr_en = psel & penable & pready & pwrite;

    // APB: zero wait states, decode in the setup cycle
    always_comb begin
        vled_en_nxt  = vled_en_r;
        imask_nxt    = imask_r;
        istat_nxt    = istat_r;
        rdata_nxt    = 32'h0;
        hit          = 1'b1;
        ready_nxt    = psel & ~penable;
        err_resp_nxt = 1'b0;
        case (paddr)
            led_sink_pkg::CTRL_OFF:
                rdata_nxt = {31'h0, vled_en_r};
            led_sink_pkg::STATE_OFF: begin
                rdata_nxt[led_sink_pkg::STATE_MODE_BIT] = special;
                rdata_nxt[led_sink_pkg::STATE_OUT_LSB +: 8] = out_r;
                rdata_nxt[led_sink_pkg::STATE_CFG_LSB +: 8] =
                    current_gain_code;
                rdata_nxt[led_sink_pkg::STATE_ERR_LSB +: 8] = err_r;
            end
            led_sink_pkg::IRQ_STAT_OFF:
                rdata_nxt = {29'h0, istat_r};
            led_sink_pkg::IRQ_MASK_OFF:
                rdata_nxt = {29'h0, imask_r};
            default:
                hit = 1'b0;
        endcase
        if (!(psel && !penable)) begin
            rdata_nxt = prdata;
        end else begin
            err_resp_nxt = ~hit;
        end
        if (wr_en && paddr == led_sink_pkg::CTRL_OFF) begin
            vled_en_nxt = pwdata[led_sink_pkg::CTRL_VLED_BIT];
        end
        if (wr_en && paddr == led_sink_pkg::IRQ_MASK_OFF) begin
            imask_nxt = pwdata[2:0];
        end
        // Write one to clear; a same-cycle event wins
        if (wr_en && paddr == led_sink_pkg::IRQ_STAT_OFF) begin
            istat_nxt = istat_r & ~pwdata[2:0];
        end
        istat_nxt = istat_nxt | ev;
        irq_nxt   = |(istat_nxt & imask_nxt);
    end

    // Bus and interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vled_en_r <= led_sink_pkg::CTRL_VLED_RST;
            imask_r   <= led_sink_pkg::IRQ_MASK_RST;
            istat_r   <= 3'h0;
            irq       <= 1'b0;
            prdata    <= 32'h0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
        end else begin
            vled_en_r <= vled_en_nxt;
            imask_r   <= imask_nxt;
            istat_r   <= istat_nxt;
            irq       <= irq_nxt;
            prdata    <= rdata_nxt;
            pready    <= ready_nxt;
            pslverr   <= err_resp_nxt;
        end
    end

    // Checks on the pin side behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    shift_in_a: assert property (edge_c && !(special && !oe_n) |=>
        shift_r == {$past(shift_r[6:0]), $past(pins_s.serial_in)})
        else $error("shift register did not take serial input");
    sout_seven_a: assert property (edge_c && !(special && !oe_n) |=>
        serial_out == $past(shift_r[6]))
        else $error("serial output not one stage ahead");
    latch_pass_a: assert property (le && !special |=>
        out_r == $past(shift_r) && $stable(current_gain_code))
        else $error("output latch not loaded on strobe");
    latch_hold_a: assert property (!le |=>
        $stable(out_r) && $stable(current_gain_code))
        else $error("latches changed with strobe low");
    cfg_write_a: assert property (le && special |=>
        current_gain_code == $past(shift_r) && $stable(out_r))
        else $error("configuration latch not loaded");
    blank_out_a: assert property (oe_n |=> sink_outputs == 8'h00)
        else $error("outputs not blanked");
    enable_out_a: assert property (!oe_n |=> sink_outputs == out_r)
        else $error("outputs not following latch");
    err_load_a: assert property (edge_c && special && !oe_n |=>
        shift_r == $past(err_r))
        else $error("error status not loaded");
    err_set_a: assert property (err_set != 8'h00 |=>
        (err_r & $past(err_set)) == $past(err_set))
        else $error("fault did not set error bit");
    err_clear_a: assert property (to_normal |=>
        !special && err_r == $past(err_set))
        else $error("error bits not cleared");
    mode_sel_a: assert property (edge_c && oe_n
        && sw_r == led_sink_pkg::SW_LOW1 |=> mode_r == $past(le_cap_r))
        else $error("mode not taken from strobe");
    long_low_a: assert property (sw_r == led_sink_pkg::SW_LONG |=>
        $stable(mode_r))
        else $error("long enable low changed mode");

    enter_special_c: cover property (!special ##1 special);
    back_normal_c:   cover property (to_normal ##1 !special);
    cfg_written_c:   cover property (le && special);
    err_read_c:      cover property (edge_c && special && !oe_n
        && err_r != 8'h00);

endmodule

// [dv/led_ctl_model.sv]
`timescale 1ns/1ps
// Controller side of the pin link; pins change just after pclk edges
module led_ctl_model (
    // Clock
    input  wire logic           pclk,
    // Pins towards the driver
    output led_sink_pkg::pins_t pins
);
    // Sync takes up to 3 cycles, so hold every level for 4
    localparam int HOLD = 4;

    // Idle levels: shift clock still, strobe low, enable high
    initial begin
        pins = led_sink_pkg::PINS_RST;
    end

    // Strobe and enable levels between shift clock edges
    task automatic set(input logic le, input logic oe_n);
        @(posedge pclk);
        pins.latch_strobe_mode_sel    <= le;
        pins.output_enable_n_mode_ctl <= oe_n;
        repeat (HOLD) @(posedge pclk);
    endtask

    // One shift clock pulse with the given levels around it
    task automatic pulse(input logic sin, input logic le, input logic oe_n);
        @(posedge pclk);
        pins.serial_in                <= sin;
        pins.latch_strobe_mode_sel    <= le;
        pins.output_enable_n_mode_ctl <= oe_n;
        repeat (HOLD) @(posedge pclk);
        pins.shift_clk <= 1'b1;
        repeat (HOLD) @(posedge pclk);
        pins.shift_clk <= 1'b0;
    endtask

    // Code goes in msb first with the strobe low, latches hold
    task automatic send_byte(input logic [7:0] b, input logic oe_n);
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i], 1'b0, oe_n);
        end
    endtask

    // Enable high, exactly one low sample, high again; strobe picks mode
    task automatic mode_switch(input logic le);
        pulse(1'b1, le, 1'b1);
        pulse(1'b1, le, 1'b0);
        pulse(1'b1, le, 1'b1);
    endtask
endmodule

// [dv/led_sink_serial_control_test.sv]
`timescale 1ns/1ps
module led_sink_serial_control_test;
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    led_sink_pkg::pins_t   pins;
    logic                  serial_out;
    led_sink_pkg::faults_t faults;
    logic [7:0]            sink_outputs;
    logic [7:0]            current_gain_code;
    logic                  irq;
    logic [31:0]           rd;
    logic                  er;
    int                    n_errors;
    int                    checks_done;
    int                    cycles;

    led_sink_serial_control dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins),
        .serial_out(serial_out), .faults(faults),
        .sink_outputs(sink_outputs),
        .current_gain_code(current_gain_code), .irq(irq)
    );
    led_ctl_model ctl_u (.pclk(pclk), .pins(pins));

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Hang guard, well above the few hundred cycles needed
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready, takes data at that edge
    // Only the hang guard ends a wait that never sees pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        faults   = '0;
        presetn  = 1'b0;
        n_errors = 0;
        checks_done = 0;
        cycles   = 0;
        idle(8);
        presetn <= 1'b1;
        idle(2);
        apb(1'b0, led_sink_pkg::STATE_OFF, 32'h0);
        chk("state", rd, 32'h00000000);
        chk("gain", current_gain_code, 8'h00);
        apb(1'b0, led_sink_pkg::IRQ_MASK_OFF, 32'h0);
        chk("mask", rd, 32'h00000000);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {er, rd[30:0]}, 32'h80000000);
        $display("test reset done");
        // Normal shift, cascade output, strobe load, blanking
        ctl_u.send_byte(8'ha5, 1'b0);
        chk("sout", serial_out, 1'b1);
        ctl_u.set(1'b1, 1'b0);
        chk("sink", sink_outputs, 8'ha5);
        ctl_u.set(1'b0, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            chk("cascade", serial_out, (8'ha5 >> i) & 8'h01);
            ctl_u.pulse(1'b1, 1'b0, 1'b0);
        end
        idle(4);
        chk("held", sink_outputs, 8'ha5);
        ctl_u.set(1'b1, 1'b0);
        chk("sink2", sink_outputs, 8'hff);
        ctl_u.set(1'b0, 1'b1);
        chk("blank", sink_outputs, 8'h00);
        $display("test normal done");
        // Into special mode, then a gain code write
        ctl_u.mode_switch(1'b1);
        ctl_u.set(1'b0, 1'b1);
        apb(1'b0, led_sink_pkg::STATE_OFF, 32'h0);
        chk("mode", rd[0], 1'b1);
        ctl_u.send_byte(8'h3c, 1'b1);
        ctl_u.set(1'b1, 1'b1);
        ctl_u.set(1'b0, 1'b1);
        chk("gain", current_gain_code, 8'h3c);
        apb(1'b0, led_sink_pkg::STATE_OFF, 32'h0);
        chk("outlatch", rd[15:8], 8'hff);
        $display("test config done");
        // Faults of all four kinds, then serial readback
        apb(1'b1, led_sink_pkg::CTRL_OFF, 32'h1);
        apb(1'b1, led_sink_pkg::IRQ_MASK_OFF, 32'h1);
        faults <= {8'h20, 8'h04, 8'h01, 8'h80};
        idle(4);
        ctl_u.pulse(1'b0, 1'b0, 1'b0);
        ctl_u.pulse(1'b0, 1'b0, 1'b0);
        idle(4);
        chk("sink_sp", sink_outputs, 8'hff);
        ctl_u.set(1'b0, 1'b1);
        for (int i = 7; i >= 0; i--) begin
            chk("errbit", serial_out, (8'ha5 >> i) & 1);
            ctl_u.pulse(1'b0, 1'b0, 1'b1);
        end
        faults <= '0;
        apb(1'b0, led_sink_pkg::STATE_OFF, 32'h0);
        chk("errs", rd[31:24], 8'ha5);
        chk("irq", irq, 1'b1);
        $display("test errors done");
        // Back to normal clears the error bits
        ctl_u.mode_switch(1'b0);
        apb(1'b0, led_sink_pkg::STATE_OFF, 32'h0);
        chk("state", rd, 32'h003cff00);
        $display("test resume done");
        // Sticky status, write one to clear, mask
        apb(1'b0, led_sink_pkg::IRQ_STAT_OFF, 32'h0);
        chk("stat", rd, 32'h00000007);
        apb(1'b1, led_sink_pkg::IRQ_STAT_OFF, 32'h1);
        idle(3);
        chk("irq_clr", irq, 1'b0);
        apb(1'b1, led_sink_pkg::IRQ_MASK_OFF, 32'h2);
        idle(3);
        chk("irq_mask", irq, 1'b1);
        apb(1'b1, led_sink_pkg::IRQ_STAT_OFF, 32'h6);
        idle(3);
        chk("irq_off", irq, 1'b0);
        apb(1'b0, led_sink_pkg::IRQ_STAT_OFF, 32'h0);
        chk("stat0", rd, 32'h00000000);
        $display("test irq done");
        report_and_stop();
    end
endmodule
